// ==== hw/btod_pkg.sv ====
// constants, types and helpers of the byte transfer operand decoder
// assumes one 10 MHz clock and an Avalon-MM register slave in front
`default_nettype none
package btod_pkg;
	localparam logic [4:0] OFS_CMD  = 5'h00;
	localparam logic [4:0] OFS_OPND = 5'h04;
	localparam logic [4:0] OFS_STAT = 5'h08;
	localparam logic [4:0] OFS_EA   = 5'h0C;
	localparam logic [4:0] OFS_GLO  = 5'h10;
	localparam logic [4:0] OFS_GHI  = 5'h14;
	localparam logic [4:0] OFS_CLK  = 5'h18;
	// command word: op [3:0], reg [6:4], pair [9:8], imm [23:16]
	localparam int CMD_REG  = 4;
	localparam int CMD_PAIR = 8;
	localparam int CMD_IMM  = 16;
	// operand word: address [15:0], form [19:16]
	localparam int OPND_FORM = 16;
	// status word flag positions
	localparam int BIT_CARRY     = 0;
	localparam int BIT_AUX_CARRY = 4;
	localparam int BIT_ZERO      = 6;
	localparam logic [7:0] STATUS_WORD_RST = 8'h00;
	localparam logic [2:0] REG_X = 3'h0, REG_A = 3'h1, REG_C = 3'h2, REG_B = 3'h3;
	localparam logic [2:0] REG_E = 3'h4, REG_D = 3'h5, REG_L = 3'h6, REG_H = 3'h7;
	localparam logic [1:0] PAIR_AX = 2'h0, PAIR_BC = 2'h1, PAIR_DE = 2'h2, PAIR_HL = 2'h3;
	localparam logic [15:0] SADDR_LO = 16'hFE20, SADDR_HI = 16'hFF1F;
	localparam logic [15:0] CALL_LO  = 16'h0800, CALL_HI  = 16'h0FFF;
	localparam logic [15:0] TBL_LO   = 16'h0040, TBL_HI   = 16'h007F;
	localparam logic [15:0] SFR_LO   = 16'hFF00;
	localparam logic [15:0] GAP_LO   = 16'hFFD0, GAP_HI   = 16'hFFDF;
	localparam logic [3:0] CYC_RR = 4'h2, CYC_R_IMM = 4'h4, CYC_SW_IMM = 4'h7;
	localparam logic [3:0] CYC_SW_A = 4'h5, CYC_SHORT = 4'h4, CYC_ABS = 4'h8;
	localparam logic [3:0] CYC_HL_BYTE = 4'h8, CYC_HL_REG = 4'h6, CYC_ILL = 4'h1;
	localparam logic [3:0] CYC_LONG_ADD = 4'h1;
	localparam logic [2:0] DIV_RST = 3'h0;
	typedef enum logic [3:0] {
		OP_R_IMM = 4'h0, OP_A_R = 4'h1, OP_R_A = 4'h2, OP_SWAP = 4'h3,
		OP_SW_IMM = 4'h4, OP_A_SW = 4'h5, OP_SW_A = 4'h6, OP_EA = 4'h7,
		OP_SAVE = 4'h8, OP_RESTORE = 4'h9
	} btod_op_t;
	typedef enum logic [3:0] {
		FO_SADDR = 4'h0, FO_SADDRP = 4'h1, FO_ABS = 4'h2, FO_ABSW = 4'h3,
		FO_CALL = 4'h4, FO_TBL = 4'h5, FO_SFR = 4'h6, FO_SFRP = 4'h7,
		FO_IND_RP = 4'h8, FO_HL_BYTE = 4'h9, FO_HL_B = 4'hA, FO_HL_C = 4'hB,
		FO_REL = 4'hC, FO_BIT = 4'hD
	} btod_form_t;
	typedef enum logic [2:0] {
		FM_KEEP = 3'h0, FM_CLR = 3'h1, FM_SET = 3'h2, FM_RES = 3'h3, FM_RESTORE = 3'h4
	} btod_fmode_t;
	typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} btod_st_t;

	function automatic logic btod_flag(btod_fmode_t m, logic old, logic res, logic sav);
		unique case (m)
			FM_KEEP:    btod_flag = old;
			FM_CLR:     btod_flag = 1'b0;
			FM_SET:     btod_flag = 1'b1;
			FM_RES:     btod_flag = res;
			FM_RESTORE: btod_flag = sav;
			default:    btod_flag = old;
		endcase
	endfunction : btod_flag

	function automatic logic [7:0] btod_flags(logic [7:0] base, logic [7:0] res,
		logic [7:0] sav, btod_fmode_t m);
		btod_flags = base;
		btod_flags[BIT_ZERO]      = btod_flag(m, base[BIT_ZERO], res[BIT_ZERO], sav[BIT_ZERO]);
		btod_flags[BIT_AUX_CARRY] = btod_flag(m, base[BIT_AUX_CARRY], res[BIT_AUX_CARRY], sav[BIT_AUX_CARRY]);
		btod_flags[BIT_CARRY]     = btod_flag(m, base[BIT_CARRY], res[BIT_CARRY], sav[BIT_CARRY]);
	endfunction : btod_flags
endpackage : btod_pkg
`default_nettype wire

// ==== hw/btod_core.sv ====
// byte move and swap executor with operand decode, behind an Avalon-MM slave
// assumes a single-clock master; one command at a time, next one stalls
`timescale 1ns/100ps
`default_nettype none
module btod_core import btod_pkg::*; #(
	parameter logic [15:0]  RAM_LO   = 16'hFB00,
	parameter logic [15:0]  RAM_HI   = 16'hFEFF,
	parameter logic [127:0] SFRP_MAP = {128{1'b1}}
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest
);
	logic [7:0]  gpr [0:7];
	logic [7:0]  next_gpr [0:7];
	logic [7:0]  program_status_word, next_program_status_word, saved, next_saved;
	logic [31:0] cmd, next_cmd, opnd, next_opnd, next_rdata;
	logic [15:0] ea, next_ea;
	logic        fault, next_fault, long_c, next_long, rd_ack, next_rd_ack;
	logic [3:0]  cyc, next_cyc;
	logic [2:0]  div_sel, next_div_sel;
	logic [7:0]  div_cnt, next_div_cnt, div_mask;
	btod_st_t    st, next_st;
	logic        tick, start, f_bad, f_acc, f_long, in_ram;
	logic [15:0] f_ea, addr, pair, hl;
	logic [3:0]  f_cyc;
	logic [2:0]  w_reg;
	logic [1:0]  w_pair;
	logic [7:0]  w_imm, rd_r;
	btod_op_t    w_op;
	btod_form_t  form;

	assign w_op  = btod_op_t'(avs_writedata[3:0]);
	assign w_reg = avs_writedata[CMD_REG +: 3];
	assign w_pair = avs_writedata[CMD_PAIR +: 2];
	assign w_imm = avs_writedata[CMD_IMM +: 8];
	assign addr  = opnd[15:0];
	assign form  = btod_form_t'(opnd[OPND_FORM +: 4]);
	assign rd_r  = gpr[w_reg];
	assign pair  = {gpr[{w_pair, 1'b1}], gpr[{w_pair, 1'b0}]};
	assign hl    = {gpr[REG_H], gpr[REG_L]};
	// a command write is stalled while a command runs, and a read for one cycle; every other access answers
	assign start = avs_write && avs_address == OFS_CMD && st == ST_IDLE;
	assign avs_waitrequest = (avs_read && !rd_ack) ||
		(avs_write && avs_address == OFS_CMD && st != ST_IDLE);
	// processor clock: one tick every 2**div_sel system clocks
	assign div_mask = 8'((9'h001 << div_sel) - 9'h001);
	assign tick     = (div_cnt & div_mask) == div_mask;

	always_comb begin
		f_ea  = addr;
		f_bad = 1'b0;
		f_acc = 1'b1;
		f_cyc = CYC_SHORT;
		unique case (form)
			FO_SADDR, FO_SADDRP: begin
				f_bad = addr < SADDR_LO || addr > SADDR_HI || (form == FO_SADDRP && addr[0]);
			end
			FO_ABS, FO_ABSW: begin
				f_bad = form == FO_ABSW && addr[0];
				f_cyc = CYC_ABS;
			end
			FO_CALL: begin
				f_bad = addr < CALL_LO || addr > CALL_HI;
				f_acc = 1'b0;
			end
			FO_TBL: begin
				f_bad = addr < TBL_LO || addr > TBL_HI || addr[0];
				f_acc = 1'b0;
			end
			FO_SFR, FO_SFRP: begin
				f_bad = addr < SFR_LO || (addr >= GAP_LO && addr <= GAP_HI);
				if (form == FO_SFRP && (addr[0] || !SFRP_MAP[addr[7:1]])) begin
					f_bad = 1'b1;
				end
			end
			FO_IND_RP: f_ea = pair;
			FO_HL_BYTE: begin
				f_ea  = hl + {8'h00, w_imm};
				f_cyc = CYC_HL_BYTE;
			end
			FO_HL_B, FO_HL_C: begin
				f_ea  = hl + {8'h00, gpr[form == FO_HL_B ? REG_B : REG_C]};
				f_cyc = CYC_HL_REG;
			end
			FO_REL: begin
				f_ea  = addr + {{8{w_imm[7]}}, w_imm};
				f_acc = 1'b0;
			end
			FO_BIT: begin
				f_ea  = {8'h00, 8'(9'h001 << w_imm[2:0])};
				f_acc = 1'b0;
			end
			default: f_bad = 1'b1;
		endcase
		in_ram = f_ea >= RAM_LO && f_ea <= RAM_HI && form != FO_SFR && form != FO_SFRP;
		f_long = f_acc && !in_ram;
	end

	always_comb begin
		next_gpr     = gpr;
		next_program_status_word = program_status_word;
		next_saved   = saved;
		next_cmd     = cmd;
		next_opnd    = opnd;
		next_ea      = ea;
		next_fault   = fault;
		next_long    = long_c;
		next_cyc     = cyc;
		next_st      = st;
		next_div_sel = div_sel;
		next_div_cnt = div_cnt + 8'h01;
		next_rd_ack  = avs_read && !rd_ack;
		next_rdata   = avs_readdata;
		if (st == ST_RUN && tick) begin
			next_cyc = cyc - 4'h1;
			if (cyc == 4'h1) begin
				next_st = ST_IDLE;
			end
		end
		if (avs_write && avs_address == OFS_OPND) begin
			for (int i = 0; i < 4; i++) begin
				if (avs_byteenable[i]) begin
					next_opnd[8*i +: 8] = avs_writedata[8*i +: 8];
				end
			end
		end
		if (avs_write && avs_address == OFS_CLK && avs_byteenable[0]) begin
			next_div_sel = avs_writedata[2:0];
		end
		if (start) begin
			next_cmd   = avs_writedata;
			next_fault = 1'b0;
			next_long  = 1'b0;
			next_st    = ST_RUN;
			next_cyc   = CYC_RR;
			unique case (w_op)
				OP_R_IMM: begin
					next_gpr[w_reg] = w_imm;
					next_cyc = CYC_R_IMM;
				end
				OP_A_R: next_gpr[REG_A] = rd_r;
				OP_R_A: next_gpr[w_reg] = gpr[REG_A];
				OP_SWAP: begin
					next_gpr[w_reg] = gpr[REG_A];
					next_gpr[REG_A] = rd_r;
				end
				OP_SW_IMM: begin
					next_program_status_word = btod_flags(w_imm, w_imm, saved, FM_RES);
					next_cyc = CYC_SW_IMM;
				end
				OP_A_SW: begin
					next_gpr[REG_A] = program_status_word;
					next_cyc = CYC_SW_A;
				end
				OP_SW_A: begin
					next_program_status_word = btod_flags(gpr[REG_A], gpr[REG_A], saved, FM_RES);
					next_cyc = CYC_SW_A;
				end
				OP_EA: begin
					next_ea    = f_ea;
					next_fault = f_bad;
					next_long  = f_long;
					next_cyc   = f_cyc + (f_long ? CYC_LONG_ADD : 4'h0);
				end
				OP_SAVE: next_saved = program_status_word;
				OP_RESTORE: begin
					next_program_status_word = btod_flags(program_status_word, program_status_word, saved,
						FM_RESTORE);
				end
				default: begin
					next_fault = 1'b1;
					next_cyc   = CYC_ILL;
				end
			endcase
		end
		if (avs_read && !rd_ack) begin
			unique case (avs_address)
				OFS_CMD:  next_rdata = cmd;
				OFS_OPND: next_rdata = {12'h000, opnd[19:0]};
				OFS_STAT: next_rdata = {8'h00, saved, program_status_word, cyc, 1'b0, long_c, fault, st == ST_RUN};
				OFS_EA:   next_rdata = {16'h0000, ea};
				OFS_GLO:  next_rdata = {gpr[REG_B], gpr[REG_C], gpr[REG_A], gpr[REG_X]};
				OFS_GHI:  next_rdata = {gpr[REG_H], gpr[REG_L], gpr[REG_D], gpr[REG_E]};
				OFS_CLK:  next_rdata = {29'h0, div_sel};
				default:  next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 8; i++) begin
				gpr[i] <= 8'h00;
			end
			program_status_word <= STATUS_WORD_RST;
			saved        <= STATUS_WORD_RST;
			cmd          <= 32'h0000_0000;
			opnd         <= 32'h0000_0000;
			ea           <= 16'h0000;
			fault        <= 1'b0;
			long_c       <= 1'b0;
			cyc          <= 4'h0;
			st           <= ST_IDLE;
			div_sel      <= DIV_RST;
			div_cnt      <= 8'h00;
			rd_ack       <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			gpr          <= next_gpr;
			program_status_word <= next_program_status_word;
			saved        <= next_saved;
			cmd          <= next_cmd;
			opnd         <= next_opnd;
			ea           <= next_ea;
			fault        <= next_fault;
			long_c       <= next_long;
			cyc          <= next_cyc;
			st           <= next_st;
			div_sel      <= next_div_sel;
			div_cnt      <= next_div_cnt;
			rd_ack       <= next_rd_ack;
			avs_readdata <= next_rdata;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_rr_two;
		start && (w_op == OP_A_R || w_op == OP_SWAP) |=> cyc == CYC_RR && st == ST_RUN;
	endproperty
	a_rr_two: assert property (p_rr_two) else $error("register move count not two");

	property p_sw_write;
		start && w_op == OP_SW_IMM |=> program_status_word == $past(w_imm);
	endproperty
	a_sw_write: assert property (p_sw_write) else $error("status word not written");

	property p_move_keeps;
		start && (w_op == OP_A_R || w_op == OP_R_IMM || w_op == OP_R_A) |=> $stable(program_status_word);
	endproperty
	a_move_keeps: assert property (p_move_keeps) else $error("byte move changed flags");

	// both halves of the swap are checked against the values held before the command
	property p_swap;
		start && w_op == OP_SWAP && w_reg != REG_A |=> gpr[REG_A] == $past(gpr[w_reg])
			&& gpr[$past(w_reg)] == $past(gpr[REG_A]);
	endproperty
	a_swap: assert property (p_swap) else $error("swap lost old operand");

	property p_sw_from_a;
		start && w_op == OP_SW_A |=> program_status_word == $past(gpr[REG_A]);
	endproperty
	a_sw_from_a: assert property (p_sw_from_a) else $error("status word not loaded from accumulator");

	property p_restore;
		start && w_op == OP_RESTORE |=> program_status_word[BIT_ZERO] == $past(saved[BIT_ZERO])
			&& program_status_word[BIT_AUX_CARRY] == $past(saved[BIT_AUX_CARRY])
			&& program_status_word[BIT_CARRY] == $past(saved[BIT_CARRY]);
	endproperty
	a_restore: assert property (p_restore) else $error("flags not restored from saved copy");

	// pair numbering checked from the named halves, not from the indexed pair lookup
	property p_pair_hl;
		start && w_op == OP_EA && form == FO_IND_RP && w_pair == PAIR_HL
			|=> ea == $past({gpr[REG_H], gpr[REG_L]});
	endproperty
	a_pair_hl: assert property (p_pair_hl) else $error("pair three not read as high and low");

	property p_bit_mask;
		start && w_op == OP_EA && form == FO_BIT |=> ea[15:8] == 8'h00 && $onehot(ea[7:0]);
	endproperty
	a_bit_mask: assert property (p_bit_mask) else $error("bit operand not one of eight positions");

	property p_saddr_fault;
		start && w_op == OP_EA && form == FO_SADDR && (addr < SADDR_LO || addr > SADDR_HI) |=> fault;
	endproperty
	a_saddr_fault: assert property (p_saddr_fault) else $error("short direct out of window");

	property p_sfr_gap;
		start && w_op == OP_EA && form == FO_SFR && addr >= GAP_LO && addr <= GAP_HI |=> fault;
	endproperty
	a_sfr_gap: assert property (p_sfr_gap) else $error("reserved special area reached");

	property p_call_range;
		start && w_op == OP_EA && form == FO_CALL ##1 !fault |-> ea >= CALL_LO && ea <= CALL_HI;
	endproperty
	a_call_range: assert property (p_call_range) else $error("call target outside range");

	property p_long_count;
		start && w_op == OP_EA && f_long |=> long_c && cyc == $past(f_cyc) + 4'h1;
	endproperty
	a_long_count: assert property (p_long_count) else $error("long count not applied");

	property p_tick_only;
		st == ST_RUN && !start && !tick |=> cyc == $past(cyc);
	endproperty
	a_tick_only: assert property (p_tick_only) else $error("cycle counted without tick");

	property p_read_answer;
		avs_read && !rd_ack |=> !avs_waitrequest || !avs_read;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered in one cycle");
endmodule : btod_core
`default_nettype wire

// ==== tb/btod_core_tb_top.sv ====
// self-checking bench of btod_core: a register and flag model is compared after every command issued through exec
// assumes the default ram window and drives the Avalon-MM slave port directly
`timescale 1ns/100ps
`default_nettype none
module btod_core_tb_top import btod_pkg::*; ();
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	int          err_count = 0;
	int          comparisons = 0;
	int          n;
	int          cnt_of[10] = '{4, 2, 2, 2, 7, 5, 5, 4, 2, 2};
	logic [7:0]  rf[8];
	logic [7:0]  flags_m = 8'h00;
	logic [7:0]  sav = 8'h00;
	logic [31:0] q;

	btod_core i_btod_core (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	always #50 clk = ~clk;

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	// holds the request until waitrequest is seen low at a rising edge; n counts those edges
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		n = 0;
		avs_read      <= ~wr;
		avs_write     <= wr;
		avs_address   <= a;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 2000);
		if (n >= 2000)
			check("bus_answer", 1'b0, 1'b1);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic cmd(input logic [3:0] op, input logic [2:0] rg, input logic [1:0] p, input logic [7:0] imm);
		bus(1'b1, OFS_CMD, {8'h00, imm, 6'h00, p, 1'b0, rg, op});
	endtask : cmd

	task automatic idle;
		bus(1'b0, OFS_STAT, 32'h0);
		for (int i = 0; i < 200 && q[0] !== 1'b0; i++)
			bus(1'b0, OFS_STAT, 32'h0);
		check("idle", q[0], 1'b0);
	endtask : idle

	// a divider tick may land before the status read, so one less is also fine
	task automatic stat_cyc(input logic [3:0] c);
		bus(1'b0, OFS_STAT, 32'h0);
		check("busy", q[0], 1'b1);
		check("cycles", q[7:4] === c || q[7:4] === c - 4'h1, 1'b1);
	endtask : stat_cyc

	task automatic regs_chk;
		bus(1'b0, OFS_GLO, 32'h0);
		check("glo", q, {rf[3], rf[2], rf[1], rf[0]});
		bus(1'b0, OFS_GHI, 32'h0);
		check("ghi", q, {rf[7], rf[6], rf[5], rf[4]});
		bus(1'b0, OFS_STAT, 32'h0);
		check("flags", q[15:8] & 8'h51, flags_m);
		check("saved", q[23:16] & 8'h51, sav);
	endtask : regs_chk

	task automatic exec(input logic [3:0] op, input logic [2:0] rg, input logic [7:0] imm);
		cmd(op, rg, 2'h0, imm);
		stat_cyc(4'(cnt_of[op]));
		case (op)
			4'h0: rf[rg] = imm;
			4'h1: rf[1] = rf[rg];
			4'h2: rf[rg] = rf[1];
			4'h3: {rf[1], rf[rg]} = {rf[rg], rf[1]};
			4'h4: flags_m = imm & 8'h51;
			4'h5: rf[1] = flags_m;
			4'h6: flags_m = rf[1] & 8'h51;
			4'h8: sav = flags_m;
			4'h9: flags_m = sav;
			default: ;
		endcase
		idle;
		regs_chk;
	endtask : exec

	task automatic dec(input logic [3:0] f, input logic [15:0] a, input logic [1:0] p, input logic [7:0] imm,
		input logic flt, input logic [15:0] ea, input logic [3:0] c, input logic lng);
		bus(1'b1, OFS_OPND, {12'h000, f, a});
		cmd(4'h7, 3'h0, p, imm);
		bus(1'b0, OFS_STAT, 32'h0);
		check("fault", q[1], flt);
		if (!flt) begin
			check("long", q[2], lng);
			check("cycles", q[7:4] === c || q[7:4] === c - 4'h1, 1'b1);
		end
		idle;
		bus(1'b0, OFS_EA, 32'h0);
		if (!flt)
			check("ea", q[15:0], ea);
	endtask : dec

	initial begin
		#5_000_000;
		err_count++;
		summarize;
	end

	initial begin
		for (int i = 0; i < 8; i++)
			rf[i] = 8'h00;
		void'($urandom(35761));
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		regs_chk;
		bus(1'b0, OFS_CLK, 32'h0);
		check("clk_reset", q[2:0], 3'h0);
		bus(1'b0, 5'h1C, 32'h0);
		check("unmapped", q, 32'h0);
		// slow divider so the remaining count is still visible when read back
		bus(1'b1, OFS_CLK, 32'h4);
		bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
		bus(1'b1, OFS_STAT, 32'hFFFF_FFFF);
		bus(1'b0, OFS_CLK, 32'h0);
		check("clk_rw", q[2:0], 3'h4);
		// lane 0 switched off: the divider select must keep its value
		avs_byteenable <= 4'hE;
		bus(1'b1, OFS_CLK, 32'h7);
		avs_byteenable <= 4'hF;
		bus(1'b0, OFS_CLK, 32'h0);
		check("clk_lane", q[2:0], 3'h4);
		regs_chk;
		$display("test registers done");
		for (int i = 0; i < 8; i++)
			exec(4'h0, 3'(i), 8'($urandom));
		for (int i = 0; i < 12; i++)
			exec(4'(1 + $urandom % 3), 3'($urandom), 8'h00);
		exec(4'h3, 3'h1, 8'h00);
		$display("test moves done");
		exec(4'h4, 3'h0, 8'hFF);
		exec(4'h8, 3'h0, 8'h00);
		exec(4'h4, 3'h0, 8'h10);
		exec(4'h0, 3'h6, 8'h00);
		exec(4'h9, 3'h0, 8'h00);
		exec(4'h5, 3'h0, 8'h00);
		exec(4'h0, 3'h1, 8'h40);
		exec(4'h6, 3'h0, 8'h00);
		exec(4'h3, 3'h2, 8'h00);
		cmd(4'hA, 3'h0, 2'h0, 8'h00);
		bus(1'b0, OFS_STAT, 32'h0);
		check("op_fault", q[1], 1'b1);
		idle;
		$display("test flags done");
		exec(4'h0, 3'h7, 8'hFE);
		exec(4'h0, 3'h6, 8'h30);
		exec(4'h0, 3'h3, 8'h05);
		exec(4'h0, 3'h2, 8'hF0);
		exec(4'h0, 3'h5, 8'hFE);
		exec(4'h0, 3'h4, 8'h41);
		dec(4'h0, 16'hFE20, 2'h0, 8'h00, 1'b0, 16'hFE20, 4'h4, 1'b0);
		dec(4'h0, 16'hFF1F, 2'h0, 8'h00, 1'b0, 16'hFF1F, 4'h5, 1'b1);
		dec(4'h0, 16'hFE1F, 2'h0, 8'h00, 1'b1, 16'h0, 4'h0, 1'b0);
		dec(4'h0, 16'hFF20, 2'h0, 8'h00, 1'b1, 16'h0, 4'h0, 1'b0);
		dec(4'h1, 16'hFE23, 2'h0, 8'h00, 1'b1, 16'h0, 4'h0, 1'b0);
		dec(4'h2, 16'h1235, 2'h0, 8'h00, 1'b0, 16'h1235, 4'h9, 1'b1);
		dec(4'h3, 16'hFB00, 2'h0, 8'h00, 1'b0, 16'hFB00, 4'h8, 1'b0);
		dec(4'h3, 16'h1235, 2'h0, 8'h00, 1'b1, 16'h0, 4'h0, 1'b0);
		dec(4'h4, 16'h0FFF, 2'h0, 8'h00, 1'b0, 16'h0FFF, 4'h4, 1'b0);
		dec(4'h4, 16'h07FF, 2'h0, 8'h00, 1'b1, 16'h0, 4'h0, 1'b0);
		dec(4'h5, 16'h007E, 2'h0, 8'h00, 1'b0, 16'h007E, 4'h4, 1'b0);
		dec(4'h5, 16'h0041, 2'h0, 8'h00, 1'b1, 16'h0, 4'h0, 1'b0);
		dec(4'h6, 16'hFF10, 2'h0, 8'h00, 1'b0, 16'hFF10, 4'h5, 1'b1);
		dec(4'h6, 16'hFFDF, 2'h0, 8'h00, 1'b1, 16'h0, 4'h0, 1'b0);
		dec(4'h7, 16'hFFD2, 2'h0, 8'h00, 1'b1, 16'h0, 4'h0, 1'b0);
		dec(4'h7, 16'hFF13, 2'h0, 8'h00, 1'b1, 16'h0, 4'h0, 1'b0);
		dec(4'h8, 16'h0000, 2'h2, 8'h00, 1'b0, 16'hFE41, 4'h4, 1'b0);
		dec(4'h8, 16'h0000, 2'h1, 8'h00, 1'b0, 16'h05F0, 4'h5, 1'b1);
		dec(4'h8, 16'h0000, 2'h3, 8'h00, 1'b0, 16'hFE30, 4'h4, 1'b0);
		dec(4'h9, 16'h0000, 2'h0, 8'hFF, 1'b0, 16'hFF2F, 4'h9, 1'b1);
		dec(4'hA, 16'h0000, 2'h0, 8'h00, 1'b0, 16'hFE35, 4'h6, 1'b0);
		dec(4'hB, 16'h0000, 2'h0, 8'h00, 1'b0, 16'hFF20, 4'h7, 1'b1);
		dec(4'hC, 16'h1000, 2'h0, 8'h80, 1'b0, 16'h0F80, 4'h4, 1'b0);
		dec(4'hD, 16'h0000, 2'h0, 8'h0D, 1'b0, 16'h0020, 4'h4, 1'b0);
		dec(4'hE, 16'h0000, 2'h0, 8'h00, 1'b1, 16'h0, 4'h0, 1'b0);
		$display("test decode done");
		// a second command stalls for the whole count of the first, one count per divided tick
		bus(1'b1, OFS_CLK, 32'h0);
		cmd(4'h4, 3'h0, 2'h0, 8'h00);
		flags_m = 8'h00;
		cmd(4'h1, 3'h1, 2'h0, 8'h00);
		check("stall_div1", n >= 6 && n <= 8, 1'b1);
		idle;
		bus(1'b1, OFS_CLK, 32'h2);
		cmd(4'h1, 3'h2, 2'h0, 8'h00);
		rf[1] = rf[2];
		cmd(4'h1, 3'h1, 2'h0, 8'h00);
		check("stall_div4", n >= 4 && n <= 9, 1'b1);
		idle;
		regs_chk;
		$display("test clock done");
		summarize;
	end
endmodule : btod_core_tb_top
`default_nettype wire
